// *** src/usart_sync_port.sv ***
/*
 * Synchronous half-duplex serial port: master or slave, transmit and receive.
 * Assumes a single-cycle register port and pins from outside the clock domain.
 */
// Local design decisions: the strobed register port and the register addresses.
// Behaviour
// - Reception starts in synchronous mode when single or continuous enable is set.
// - Data line is sampled on the falling edge of the shift clock.
// - Single enable receives one word, then clears itself and stops.
// - Continuous enable keeps receiving words until software clears it or an overrun stops reception.
// - With both enables set, continuous reception wins.
// - Each received word sets the receive flag; request only when enabled.
// - Ninth received bit and error flags read from receive control.
// - Eight received data bits are read from receive data.
// - Clearing continuous enable clears a pending overrun error.
// - Clearing clock source select puts the port in slave mode.
// - Slave mode keeps shifting while the core sleeps.
// - Slave transmit: first word shifts at once, second waits, flag clear.
// - After the first word, the second moves to shift, then flag sets.
// - Transmit flag with its enable raises a wake request.
// - Master drives the shift clock; transmit and receive exclude each other.
// - Sync select bit selects synchronous operation.
// - Transmit flag sets on transfer; only a data write clears it.
`timescale 1ns/1ps
module usart_sync_port (
  input  wire logic       clk,                 // Core clock, 40 MHz.
  input  wire logic       reset_n,             // Synchronous reset, active low.
  input  wire logic [3:0] addr,                // Register address.
  input  wire logic [7:0] wdata,               // Write data.
  input  wire logic       wr,                  // Write strobe.
  input  wire logic       rd,                  // Read strobe.
  output logic      [7:0] rdata,               // Read data, one cycle after rd.
  input  wire logic       core_sleep,          // Core is asleep.
  input  wire logic       shift_clock_line_in, // Clock pin level.
  output logic            shift_clock_line_out,  // Clock pin drive value.
  output logic            shift_clock_line_oe_n, // Clock pin enable, low drives.
  input  wire logic       shift_data_line_in,  // Data pin level.
  output logic            shift_data_line_out,   // Data pin drive value.
  output logic            shift_data_line_oe_n,  // Data pin enable, low drives.
  output logic            receive_irq,         // Receive request.
  output logic            transmit_irq,        // Transmit request.
  output logic            wake_request         // Wake the core.
);

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] rcv_ctrl_q, rcv_ctrl_d, rcv_data_q, rcv_data_d;
  logic [7:0] xmt_ctrl_q, xmt_ctrl_d, baud_q, baud_d;
  logic [7:0] xmt_data_q, xmt_data_d, rdata_q, rdata_d;
  logic [8:0] shreg_q, shreg_d, rcv_word;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [1:0] irq_en_q, irq_en_d;
  logic       xmt_full_q, xmt_full_d, rcv_flag_q, rcv_flag_d;
  logic       dout_q, dout_d;
  logic       ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
  usart_sync_pkg::link_state_e state_q, state_d;
  logic       sync_on, master, rcv_req, edge_rise, edge_fall;
  logic       xmt_wr, can_load, rcv_done, rcv_last, xmt_last;

  shift_clock_if bclk ();

  shift_clock_gen u_gen (
    .clk     (clk),
    .reset_n (reset_n),
    .b       (bclk)
  );

  // Word length from a ninth-bit select.
  function automatic logic [3:0] word_bits(input logic nine);
    word_bits = nine ? usart_sync_pkg::BITS_9 : usart_sync_pkg::BITS_8;
  endfunction : word_bits

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Two flops on each pin before any logic looks at it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      dt_s1_q <= 1'b0;
      dt_s2_q <= 1'b0;
    end else begin
      ck_s1_q <= shift_clock_line_in;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dt_s1_q <= shift_data_line_in;
      dt_s2_q <= dt_s1_q;
    end
  end

  // ************************************************************
  // Mode decode and shift clock edges
  // ************************************************************
  // Mode bits, and edges taken from the generator or the pin.
  assign sync_on   = xmt_ctrl_q[usart_sync_pkg::SYNC_BIT] & rcv_ctrl_q[usart_sync_pkg::PORT_EN_BIT];
  assign master    = xmt_ctrl_q[usart_sync_pkg::CLK_SRC_BIT];
  assign rcv_req   = rcv_ctrl_q[usart_sync_pkg::SINGLE_BIT] | rcv_ctrl_q[usart_sync_pkg::CONT_BIT];
  assign edge_rise = master ? bclk.rise : (ck_s2_q & ~ck_s3_q);
  assign edge_fall = master ? bclk.fall : (~ck_s2_q & ck_s3_q);
  // The core clock stops in sleep, so only the slave keeps shifting.
  assign bclk.run     = sync_on & master & (state_q != usart_sync_pkg::ST_IDLE) & ~core_sleep;
  assign bclk.divisor = baud_q;
  assign xmt_wr   = wr && (addr == usart_sync_pkg::XMT_DATA_ADDR);
  // A load waits a cycle behind a data write so the write is never lost.
  assign can_load = xmt_ctrl_q[usart_sync_pkg::TX_EN_BIT] & xmt_full_q & ~xmt_wr;
  assign rcv_last = (bitcnt_q + 4'h1) == word_bits(rcv_ctrl_q[usart_sync_pkg::RX9_SEL_BIT]);
  assign xmt_last = (bitcnt_q + 4'h1) == word_bits(xmt_ctrl_q[usart_sync_pkg::TX9_SEL_BIT]);
  assign rcv_done = (state_q == usart_sync_pkg::ST_RCV) & sync_on & rcv_req & edge_fall & rcv_last;
  // New bits enter at the top, so the first bit ends lowest.
  assign rcv_word = {dt_s2_q, shreg_q[8:1]};

  // ************************************************************
  // Registers and link sequencer
  // ************************************************************
  // Bus access first; hardware updates follow so that a set wins.
  always_comb begin
    rcv_ctrl_d = rcv_ctrl_q;
    rcv_data_d = rcv_data_q;
    xmt_ctrl_d = xmt_ctrl_q;
    baud_d     = baud_q;
    xmt_data_d = xmt_data_q;
    xmt_full_d = xmt_full_q;
    rcv_flag_d = rcv_flag_q;
    irq_en_d   = irq_en_q;
    shreg_d    = shreg_q;
    bitcnt_d   = bitcnt_q;
    dout_d     = dout_q;
    state_d    = state_q;
    rdata_d    = usart_sync_pkg::BYTE_RST;
    if (wr) begin
      if (addr == usart_sync_pkg::RCV_CTRL_ADDR) begin
        rcv_ctrl_d = (wdata & usart_sync_pkg::RCV_CTRL_WMASK) | (rcv_ctrl_q & ~usart_sync_pkg::RCV_CTRL_WMASK);
        if (!wdata[usart_sync_pkg::CONT_BIT]) begin
          rcv_ctrl_d[usart_sync_pkg::OVERRUN_BIT] = 1'b0;
        end
      end else if (addr == usart_sync_pkg::XMT_CTRL_ADDR) begin
        xmt_ctrl_d = (wdata & usart_sync_pkg::XMT_CTRL_WMASK) | (xmt_ctrl_q & ~usart_sync_pkg::XMT_CTRL_WMASK);
      end else if (addr == usart_sync_pkg::BAUD_ADDR) begin
        baud_d = wdata;
      end else if (addr == usart_sync_pkg::XMT_DATA_ADDR) begin
        xmt_data_d = wdata;
        xmt_full_d = 1'b1;
      end else if (addr == usart_sync_pkg::IRQ_EN_ADDR) begin
        irq_en_d = wdata[1:0];
      end
    end
    if (rd) begin
      if (addr == usart_sync_pkg::RCV_CTRL_ADDR) begin
        rdata_d = rcv_ctrl_q;
      end else if (addr == usart_sync_pkg::RCV_DATA_ADDR) begin
        rdata_d    = rcv_data_q;
        rcv_flag_d = 1'b0;
      end else if (addr == usart_sync_pkg::XMT_CTRL_ADDR) begin
        rdata_d = xmt_ctrl_q;
      end else if (addr == usart_sync_pkg::BAUD_ADDR) begin
        rdata_d = baud_q;
      end else if (addr == usart_sync_pkg::XMT_DATA_ADDR) begin
        rdata_d = xmt_data_q;
      end else if (addr == usart_sync_pkg::FLAG_ADDR) begin
        rdata_d = {6'h00, ~xmt_full_q, rcv_flag_q};
      end else if (addr == usart_sync_pkg::IRQ_EN_ADDR) begin
        rdata_d = {6'h00, irq_en_q};
      end
    end
    case (state_q)
      usart_sync_pkg::ST_IDLE: begin
        xmt_ctrl_d[usart_sync_pkg::SR_EMPTY_BIT] = 1'b1;
        bitcnt_d = 4'h0;
        if (sync_on && rcv_req && !rcv_ctrl_q[usart_sync_pkg::OVERRUN_BIT]) begin
          state_d = usart_sync_pkg::ST_RCV;
        end else if (sync_on && !rcv_req && can_load) begin
          shreg_d    = {xmt_ctrl_q[usart_sync_pkg::TX9_DATA_BIT], xmt_data_q};
          dout_d     = xmt_data_q[0];
          xmt_full_d = 1'b0;
          xmt_ctrl_d[usart_sync_pkg::SR_EMPTY_BIT] = 1'b0;
          state_d    = usart_sync_pkg::ST_XMT;
        end
      end
      usart_sync_pkg::ST_XMT: begin
        if (!sync_on || !xmt_ctrl_q[usart_sync_pkg::TX_EN_BIT]) begin
          state_d = usart_sync_pkg::ST_IDLE;
        end else if (edge_fall && xmt_last) begin
          bitcnt_d = 4'h0;
          if (can_load) begin
            shreg_d    = {xmt_ctrl_q[usart_sync_pkg::TX9_DATA_BIT], xmt_data_q};
            dout_d     = xmt_data_q[0];
            xmt_full_d = 1'b0;
          end else begin
            state_d = usart_sync_pkg::ST_IDLE;
          end
        end else if (edge_fall) begin
          bitcnt_d = bitcnt_q + 4'h1;
        end else if (edge_rise && bitcnt_q != 4'h0) begin
          shreg_d = {1'b0, shreg_q[8:1]};
          dout_d  = shreg_q[1];
        end
      end
      usart_sync_pkg::ST_RCV: begin
        if (!sync_on || !rcv_req) begin
          state_d = usart_sync_pkg::ST_IDLE;
        end else if (edge_fall) begin
          shreg_d  = rcv_word;
          bitcnt_d = bitcnt_q + 4'h1;
          if (rcv_last) begin
            bitcnt_d = 4'h0;
            if (rcv_flag_q) begin
              rcv_ctrl_d[usart_sync_pkg::OVERRUN_BIT] = 1'b1;
              state_d = usart_sync_pkg::ST_IDLE;
            end else if (rcv_ctrl_q[usart_sync_pkg::RX9_SEL_BIT]) begin
              rcv_data_d = rcv_word[7:0];
              rcv_ctrl_d[usart_sync_pkg::RX9_DATA_BIT] = rcv_word[8];
              rcv_flag_d = 1'b1;
            end else begin
              rcv_data_d = rcv_word[8:1];
              rcv_flag_d = 1'b1;
            end
            if (!rcv_ctrl_q[usart_sync_pkg::CONT_BIT]) begin
              rcv_ctrl_d[usart_sync_pkg::SINGLE_BIT] = 1'b0;
              state_d = usart_sync_pkg::ST_IDLE;
            end
          end
        end
      end
      default: state_d = usart_sync_pkg::ST_IDLE;
    endcase
  end

  // Register everything computed above.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rcv_ctrl_q <= usart_sync_pkg::RCV_CTRL_RST;
      rcv_data_q <= usart_sync_pkg::BYTE_RST;
      xmt_ctrl_q <= usart_sync_pkg::XMT_CTRL_RST;
      baud_q     <= usart_sync_pkg::BYTE_RST;
      xmt_data_q <= usart_sync_pkg::BYTE_RST;
      rdata_q    <= usart_sync_pkg::BYTE_RST;
      xmt_full_q <= 1'b0;
      rcv_flag_q <= 1'b0;
      irq_en_q   <= 2'h0;
      shreg_q    <= 9'h000;
      bitcnt_q   <= 4'h0;
      dout_q     <= 1'b0;
      state_q    <= usart_sync_pkg::ST_IDLE;
    end else begin
      rcv_ctrl_q <= rcv_ctrl_d;
      rcv_data_q <= rcv_data_d;
      xmt_ctrl_q <= xmt_ctrl_d;
      baud_q     <= baud_d;
      xmt_data_q <= xmt_data_d;
      rdata_q    <= rdata_d;
      xmt_full_q <= xmt_full_d;
      rcv_flag_q <= rcv_flag_d;
      irq_en_q   <= irq_en_d;
      shreg_q    <= shreg_d;
      bitcnt_q   <= bitcnt_d;
      dout_q     <= dout_d;
      state_q    <= state_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Pins, read data and requests.
  assign rdata                 = rdata_q;
  assign shift_clock_line_out  = bclk.level;
  assign shift_clock_line_oe_n = ~(sync_on & master);
  assign shift_data_line_out   = dout_q;
  assign shift_data_line_oe_n  = (state_q != usart_sync_pkg::ST_XMT);
  assign receive_irq   = rcv_flag_q & irq_en_q[usart_sync_pkg::RCV_FLAG_BIT];
  assign transmit_irq  = ~xmt_full_q & irq_en_q[usart_sync_pkg::XMT_FLAG_BIT];
  assign wake_request  = receive_irq | transmit_irq;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence xmt_last_full_s;
    state_q == usart_sync_pkg::ST_XMT && sync_on && xmt_ctrl_q[usart_sync_pkg::TX_EN_BIT] &&
      edge_fall && xmt_last && can_load;
  endsequence
  sequence reload_done_s;
    !xmt_full_q && state_q == usart_sync_pkg::ST_XMT && bitcnt_q == 4'h0;
  endsequence

  rcv_start_a: assert property (
    state_q == usart_sync_pkg::ST_IDLE && sync_on && rcv_req && !rcv_ctrl_q[usart_sync_pkg::OVERRUN_BIT]
      |=> state_q == usart_sync_pkg::ST_RCV) else $error("reception did not start");
  fall_sample_a: assert property (
    state_q == usart_sync_pkg::ST_RCV && sync_on && rcv_req && edge_fall |=> shreg_q[8] == $past(dt_s2_q))
    else $error("data not sampled on falling edge");
  single_stop_a: assert property (
    rcv_done && !rcv_ctrl_q[usart_sync_pkg::CONT_BIT] |=>
      !rcv_ctrl_q[usart_sync_pkg::SINGLE_BIT] && state_q == usart_sync_pkg::ST_IDLE)
    else $error("single reception did not stop");
  cont_keep_a: assert property (
    rcv_done && rcv_ctrl_q[usart_sync_pkg::CONT_BIT] && !rcv_flag_q && !wr |=> state_q == usart_sync_pkg::ST_RCV)
    else $error("continuous reception stopped");
  both_set_a: assert property (
    rcv_done && rcv_ctrl_q[usart_sync_pkg::CONT_BIT] && rcv_ctrl_q[usart_sync_pkg::SINGLE_BIT] && !wr
      |=> rcv_ctrl_q[usart_sync_pkg::SINGLE_BIT]) else $error("single bit cleared under continuous");
  rcv_copy_a: assert property (
    rcv_done && !rcv_flag_q && !rcv_ctrl_q[usart_sync_pkg::RX9_SEL_BIT] |=>
      rcv_flag_q && rcv_data_q == $past(rcv_word[8:1])) else $error("word not copied with flag");
  overrun_clr_a: assert property (
    wr && addr == usart_sync_pkg::RCV_CTRL_ADDR && !wdata[usart_sync_pkg::CONT_BIT] && !(rcv_done && rcv_flag_q)
      |=> !rcv_ctrl_q[usart_sync_pkg::OVERRUN_BIT]) else $error("overrun not cleared");
  reload_a: assert property (xmt_last_full_s |=> reload_done_s)
    else $error("second word not moved to shift register");
  xmt_hold_a: assert property (
    xmt_full_q && !(state_q != usart_sync_pkg::ST_RCV && can_load) |=> xmt_full_q)
    else $error("transmit flag set without a transfer");
  wake_a: assert property (
    $rose(!xmt_full_q) && irq_en_q[usart_sync_pkg::XMT_FLAG_BIT] |-> wake_request)
    else $error("no wake on transmit flag");
  half_duplex_a: assert property (
    rcv_req && state_q != usart_sync_pkg::ST_XMT |=> shift_data_line_oe_n) else $error("data driven while receiving");
  slave_clk_a: assert property (
    !master |-> shift_clock_line_oe_n) else $error("clock driven in slave mode");
  sync_off_a: assert property (
    !sync_on |=> state_q == usart_sync_pkg::ST_IDLE) else $error("link active outside synchronous mode");

endmodule : usart_sync_port

// *** inc/usart_sync_pkg.sv ***
/*
 * Constants, register map and state type of the synchronous serial port.
 * Assumes a single core clock domain and an 8-bit register port.
 */
package usart_sync_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  RCV_CTRL_ADDR = 4'h0;
  localparam logic [3:0]  RCV_DATA_ADDR = 4'h1;
  localparam logic [3:0]  XMT_CTRL_ADDR = 4'h2;
  localparam logic [3:0]  BAUD_ADDR     = 4'h3;
  localparam logic [3:0]  XMT_DATA_ADDR = 4'h4;
  localparam logic [3:0]  FLAG_ADDR     = 4'h5;
  localparam logic [3:0]  IRQ_EN_ADDR   = 4'h6;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int PORT_EN_BIT  = 7;
  localparam int RX9_SEL_BIT  = 6;
  localparam int SINGLE_BIT   = 5;
  localparam int CONT_BIT     = 4;
  localparam int OVERRUN_BIT  = 1;
  localparam int RX9_DATA_BIT = 0;
  localparam int CLK_SRC_BIT  = 7;
  localparam int TX9_SEL_BIT  = 6;
  localparam int TX_EN_BIT    = 5;
  localparam int SYNC_BIT     = 4;
  localparam int SR_EMPTY_BIT = 1;
  localparam int TX9_DATA_BIT = 0;
  localparam int RCV_FLAG_BIT = 0;
  localparam int XMT_FLAG_BIT = 1;

  // ************************************************************
  // Reset values, write masks and word lengths
  // ************************************************************
  localparam logic [7:0] RCV_CTRL_RST   = 8'h00;
  localparam logic [7:0] XMT_CTRL_RST   = 8'h02;
  localparam logic [7:0] BYTE_RST       = 8'h00;
  localparam logic [7:0] RCV_CTRL_WMASK = 8'hF8;
  localparam logic [7:0] XMT_CTRL_WMASK = 8'hF5;
  localparam logic [3:0] BITS_8         = 4'h8;
  localparam logic [3:0] BITS_9         = 4'h9;

  typedef enum logic [1:0] {ST_IDLE, ST_XMT, ST_RCV} link_state_e;

endpackage : usart_sync_pkg

// *** inc/shift_clock_if.sv ***
/*
 * Carrier between the port and its shift clock generator.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface shift_clock_if;
  logic [7:0] divisor;
  logic       run;
  logic       level;
  logic       rise;
  logic       fall;
  modport gen  (input divisor, input run, output level, output rise, output fall);
  modport user (output divisor, output run, input level, input rise, input fall);
endinterface : shift_clock_if

// *** src/shift_clock_gen.sv ***
/*
 * Master shift clock generator: a half period lasts divisor + 1 core clocks.
 * Assumes run is a registered level from the same clock domain.
 */
`timescale 1ns/1ps
module shift_clock_gen (
  input  wire logic   clk,     // Core clock.
  input  wire logic   reset_n, // Synchronous reset, active low.
  shift_clock_if.gen  b        // Divisor in, clock level and edge pulses out.
);

  logic [7:0] cnt_q, cnt_d;
  logic       level_q, level_d;
  logic       rise_q, rise_d;
  logic       fall_q, fall_d;

  // Count to the divisor and toggle; the clock idles low while stopped.
  always_comb begin
    cnt_d   = cnt_q;
    level_d = level_q;
    rise_d  = 1'b0;
    fall_d  = 1'b0;
    if (!b.run) begin
      cnt_d   = 8'h00;
      level_d = 1'b0;
      fall_d  = level_q;
    end else if (cnt_q == b.divisor) begin
      cnt_d   = 8'h00;
      level_d = ~level_q;
      rise_d  = ~level_q;
      fall_d  = level_q;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // Register the generator state.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q   <= 8'h00;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
    end
  end

  assign b.level = level_q;
  assign b.rise  = rise_q;
  assign b.fall  = fall_q;

  // Once the generator stops, the clock line drops low within a cycle and then stays still.
  stop_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !b.run ##1 !b.run |=> !level_q && !rise_q)
    else $error("shift clock moved while stopped");

endmodule : shift_clock_gen

// *** tb/sync_node_model.sv ***
/*
 * Far-side synchronous serial node: feeds words to a master port and clocks words out of a slave port.
 * Assumes the bench resolves the shared clock and data wires from every party's enable.
 */
`timescale 1ns/1ps
module sync_node_model (
  input  wire logic ck_in,   // Clock line level.
  input  wire logic dt_in,   // Data line level.
  output logic      ck_out,  // Clock driven in slave mode.
  output logic      ck_oe_n, // Clock enable, low drives.
  output logic      dt_out   // Data offered to the port.
);
  // The clock stands still and released outside frames.
  initial begin
    ck_out  = 1'b0;
    ck_oe_n = 1'b1;
    dt_out  = 1'b0;
  end
  // Offers one word of n bits LSB first, each bit put out at a rising edge, then parks the inverse.
  task automatic send_word(input logic [8:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ck_in);
      dt_out = b[i];
    end
    @(negedge ck_in);
    #60 dt_out = ~b[n-1]; // A released line must not keep its last bit.
  endtask : send_word
  // Supplies n clock pulses of 200 ns and samples the data line at each falling edge.
  task automatic recv_word(input int n, output logic [8:0] b);
    b       = 9'h000;
    ck_oe_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      ck_out = 1'b1;
      #100 ck_out = 1'b0;
      b[i] = dt_in;
      #100;
    end
    ck_oe_n = 1'b1;
  endtask : recv_word
endmodule : sync_node_model

// *** tb/tb_usart_sync_rx_and_slave_tx.sv ***
/*
 * Self-checking bench of the synchronous port: register defaults, master reception, slave transmission.
 * Assumes the port, its package, interface and the far-side node model are compiled first.
 */
`timescale 1ns/1ps
module tb_usart_sync_rx_and_slave_tx;
  typedef struct packed {logic [3:0] a; logic [7:0] v;} row_s;
  logic       clk        = 1'b0;
  logic       reset_n    = 1'b0;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic       core_sleep = 1'b0;
  logic [7:0] rdata;
  logic [8:0] got;
  logic       ck_o, ck_oe_n, dt_o, dt_oe_n, n_ck, n_ck_oe_n, n_dt, rx_irq, tx_irq, wake;
  int         mismatches = 0;
  int         num_checks = 0;
  // Reset rows: address read and the value it must give, an unmapped one last.
  row_s       rows [8] = '{'{4'h0, 8'h00}, '{4'h1, 8'h00}, '{4'h2, 8'h02}, '{4'h3, 8'h00},
                           '{4'h4, 8'h00}, '{4'h5, 8'h02}, '{4'h6, 8'h00}, '{4'hF, 8'h00}};
  // The port wins a wire where it drives; otherwise the node's level shows.
  wire        ck_w = !ck_oe_n ? ck_o : (!n_ck_oe_n ? n_ck : 1'b0);
  wire        dt_w = !dt_oe_n ? dt_o : n_dt;

  // The core clock toggles every half period of 12.5 ns.
  always #12.5 clk = ~clk;

  usart_sync_port u_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .core_sleep(core_sleep), .shift_clock_line_in(ck_w), .shift_clock_line_out(ck_o),
    .shift_clock_line_oe_n(ck_oe_n), .shift_data_line_in(dt_w), .shift_data_line_out(dt_o),
    .shift_data_line_oe_n(dt_oe_n), .receive_irq(rx_irq), .transmit_irq(tx_irq), .wake_request(wake));
  sync_node_model u_node (.ck_in(ck_w), .dt_in(dt_w), .ck_out(n_ck), .ck_oe_n(n_ck_oe_n), .dt_out(n_dt));

  // ************************************************************
  // Bus cycles, comparison and closing
  // ************************************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rreg
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // A hang is cut short well beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // Main sequence: defaults, master reception, slave transmission in sleep, reset in mid-run.
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) rreg(rows[i].a, rows[i].v);
    wreg(4'h3, 8'h03);
    wreg(4'h2, 8'h90);
    wreg(4'h6, 8'h01);
    fork
      u_node.send_word(9'h05A, 8);
      wreg(4'h0, 8'hA0);
    join
    for (int n = 0; n < 200 && rx_irq !== 1'b1; n++) @(posedge clk);
    chk({7'h00, rx_irq}, 8'h01);
    rreg(4'h1, 8'h5A);
    rreg(4'h0, 8'h80);
    chk({7'h00, rx_irq}, 8'h00);
    // Both enables set: two words arrive unread, so the second must overrun.
    fork
      begin
        u_node.send_word(9'h0C3, 8);
        u_node.send_word(9'h03C, 8);
      end
      wreg(4'h0, 8'hB0);
    join
    repeat (4) @(posedge clk); // Pin synchroniser plus edge flop.
    rreg(4'h0, 8'hB2);
    rreg(4'h1, 8'hC3);
    wreg(4'h0, 8'h80);
    rreg(4'h0, 8'h80);
    // One nine-bit word: the ninth bit lands in receive control, the byte in receive data.
    fork
      u_node.send_word(9'h1A5, 9);
      wreg(4'h0, 8'hE0);
    join
    repeat (4) @(posedge clk);
    rreg(4'h0, 8'hC1);
    rreg(4'h1, 8'hA5);
    // Slave transmission of two queued words while the core sleeps.
    wreg(4'h2, 8'h30);
    wreg(4'h6, 8'h02);
    wreg(4'h4, 8'hA5);
    wreg(4'h4, 8'h3C);
    core_sleep <= 1'b1;
    rreg(4'h5, 8'h00);
    chk({5'h00, ck_oe_n, dt_oe_n, wake}, 8'h04);
    u_node.recv_word(8, got);
    chk(got[7:0], 8'hA5);
    chk({6'h00, tx_irq, wake}, 8'h03);
    u_node.recv_word(8, got);
    chk(got[7:0], 8'h3C);
    // Nine-bit slave word: the ninth bit is written before the data and shifts out last.
    wreg(4'h2, 8'h71);
    wreg(4'h4, 8'h96);
    rreg(4'h2, 8'h71);
    u_node.recv_word(9, got);
    chk(got[7:0], 8'h96);
    chk({7'h00, got[8]}, 8'h01);
    // Reset in mid-run: pins released and every register back to its default.
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk({5'h00, ck_oe_n, dt_oe_n, wake}, 8'h06);
    foreach (rows[i]) rreg(rows[i].a, rows[i].v);
    report_and_stop();
  end
endmodule : tb_usart_sync_rx_and_slave_tx
